// File: src/tscl_pkg.sv
`default_nettype none
package tscl_pkg;
  // Register pointers
  localparam logic [3:0] PTR_TEMP = 4'h0;
  localparam logic [3:0] PTR_CFG  = 4'h1;
  localparam logic [3:0] PTR_LOW  = 4'h2;
  localparam logic [3:0] PTR_HIGH = 4'h3;
  localparam logic [3:0] PTR_ID   = 4'hf;

  // Values after reset
  localparam logic [15:0] CFG_RST_FULL = 16'h00ff;
  localparam logic [15:0] CFG_RST_RED  = 16'h60a0;
  localparam logic [15:0] LOW_RST      = 16'h4b00;
  localparam logic [15:0] HIGH_RST     = 16'h5000;
  localparam logic [7:0]  SPARE_RED    = 8'ha0;
  localparam logic [1:0]  RATE_RED     = 2'h3;

  // Field positions in the configuration word
  localparam int OS_BIT = 15;

  // Timing: one tick of the conversion timer is 500 us
  localparam int CLK_MHZ   = 100;
  localparam int TICK_US   = 500;
  localparam int TICK_CYC  = TICK_US * CLK_MHZ;
  localparam int RATE0_US  = 27500;
  localparam int RATE1_US  = 55000;
  localparam int RATE2_US  = 110000;
  localparam int RATE3_US  = 220000;
  localparam int RATER_US  = 35000;
  localparam logic [8:0] PER0 = 9'(RATE0_US / TICK_US);
  localparam logic [8:0] PER1 = 9'(RATE1_US / TICK_US);
  localparam logic [8:0] PER2 = 9'(RATE2_US / TICK_US);
  localparam logic [8:0] PER3 = 9'(RATE3_US / TICK_US);
  localparam logic [8:0] PERR = 9'(RATER_US / TICK_US);

  // Fault queue depths
  localparam logic [2:0] FQ_FULL2 = 3'h3;
  localparam logic [2:0] FQ_FULL3 = 3'h4;
  localparam logic [2:0] FQ_RED2  = 3'h4;
  localparam logic [2:0] FQ_RED3  = 3'h6;

  // Stored configuration fields, bits 14:0 of the word
  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] faults;
    logic       alert_level_invert;
    logic       tm;
    logic       sd;
    logic [7:0] spare;
  } tscl_cfg_t;

  // Byte written by the host, with its place in the word
  typedef struct packed {
    logic       hi;
    logic       lo;
    logic [3:0] ptr;
    logic [7:0] data;
  } tscl_wr_t;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK
  } tscl_st_t;
endpackage : tscl_pkg
`default_nettype wire

// File: src/tscl_sync.sv
`default_nettype none
module tscl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two stages; only the second is read outside
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : tscl_sync
`default_nettype wire

// File: src/tscl_regs.sv
// What this block does
// [RULE_01] Writing one_shot starts one conversion; reads zero
// [RULE_02] Rate field selects continuous conversion period; reduced variant forces it to 3 with the RATER_US period
// [RULE_03] Fault field sets consecutive faults to flag
// [RULE_04] alert_level_invert picks flag pin active level
// [RULE_05] flag_behavior_select picks comparator or interrupt behaviour
// [RULE_06] shutdown_request stops continuous conversion
// [RULE_07] Config low byte is spare storage; reduced variant keeps A0h there and ignores writes
// [RULE_08] Single-byte config write loads bits 15-8 only
// [RULE_09] Single-byte config read returns bits 15-8
// [RULE_10] Low threshold 12-bit, resets 4B00h
// [RULE_11] High threshold 12-bit, resets 5000h
// [RULE_12] Identifier word is read-only
// [RULE_13] Identifier exists only on full variant
// [RULE_14] Comparator flag has hysteresis and fault count
// [RULE_15] Interrupt flag cleared by read, response, shutdown
// [RULE_16] Interrupt history cleared by mode change, shutdown
// [RULE_17] Pointer selects register; read-only writes ignored
`default_nettype none
module tscl_regs #(
  parameter logic [6:0]  DEV_ADDR    = 7'h48,
  parameter bit          REDUCED     = 1'b0,
  parameter int          TICK_CYCLES = tscl_pkg::TICK_CYC,
  // Arbitrary identifier value
  parameter logic [15:0] DIE_ID      = 16'h5a00
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Two-wire bus pins
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_N,
  // Threshold flag pin, open drain
  output logic             ALERT_O,
  output logic             ALERT_OE_N,
  // Conversion engine
  input  wire logic [11:0] TEMP_RESULT,
  input  wire logic        TEMP_VALID,
  input  wire logic        ALERT_RESP_OK,
  output logic             CONV_START,
  output logic             SHUTDOWN
);
  tscl_pkg::tscl_cfg_t cfg_q;
  tscl_pkg::tscl_st_t  st_q;
  tscl_pkg::tscl_wr_t  wr_q;
  logic [15:0] low_q, high_q, rd_word;
  logic [1:0]  pins_s;
  logic        scl_s, sda_s, scl_d_q, sda_d_q;
  logic        scl_rise, scl_fall, start_c, stop_c;
  logic [3:0]  ptr_q, bitcnt_q;
  logic [7:0]  sh_q, tx_q;
  logic [1:0]  bidx_q;
  logic        rw_q, lo_sel_q, nack_q, rd_evt_q, os_q;
  logic [15:0] tick_q;
  logic [8:0]  per_q, per_len;
  logic        per_done_q;
  logic [2:0]  fcnt_q, depth;
  logic        flag_q, look_low_q, tm_prev_q, sd_prev_q;
  logic        above, below, cond, tm_chg, sd_rise, hist_clr, clr_evt;

  tscl_sync #(.W(2)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({SCL_I, SDA_I}),
    .q   (pins_s)
  );
  assign scl_s    = pins_s[1];
  assign sda_s    = pins_s[0];
  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  assign start_c  = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_c   = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // Word returned for the current pointer
  always_comb begin
    unique case (ptr_q)
      tscl_pkg::PTR_TEMP: rd_word = {TEMP_RESULT, 4'h0};
      tscl_pkg::PTR_CFG:  rd_word = {1'b0, cfg_q};            // [RULE_01]
      tscl_pkg::PTR_LOW:  rd_word = low_q;
      tscl_pkg::PTR_HIGH: rd_word = high_q;
      tscl_pkg::PTR_ID:   rd_word = REDUCED ? 16'h0000 : DIE_ID; // [RULE_13]
      default:            rd_word = 16'h0000;
    endcase
  end

  // Bus slave: bits sampled on SCL rise, driven after SCL fall
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q     <= tscl_pkg::ST_IDLE;
      scl_d_q  <= 1'b1;
      sda_d_q  <= 1'b1;
      bitcnt_q <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      bidx_q   <= 2'h0;
      rw_q     <= 1'b0;
      lo_sel_q <= 1'b0;
      nack_q   <= 1'b0;
      rd_evt_q <= 1'b0;
      SDA_OE_N <= 1'b1;
      wr_q     <= '0;
    end else begin
      scl_d_q  <= scl_s;
      sda_d_q  <= sda_s;
      rd_evt_q <= 1'b0;
      wr_q.hi  <= 1'b0;
      wr_q.lo  <= 1'b0;
      if (start_c) begin
        st_q     <= tscl_pkg::ST_ADDR;
        bitcnt_q <= 4'h0;
        bidx_q   <= 2'h0;
        SDA_OE_N <= 1'b1;
      end else if (stop_c) begin
        st_q     <= tscl_pkg::ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else begin
        unique case (st_q)
          tscl_pkg::ST_IDLE: ;
          tscl_pkg::ST_ADDR, tscl_pkg::ST_WBYTE: begin
            if (scl_rise) begin
              sh_q     <= {sh_q[6:0], sda_s};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (scl_fall && bitcnt_q == 4'h8) begin
              bitcnt_q <= 4'h0;
              if (st_q == tscl_pkg::ST_ADDR) begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  st_q     <= tscl_pkg::ST_AACK;
                  rw_q     <= sh_q[0];
                  SDA_OE_N <= 1'b0;
                end else begin
                  st_q <= tscl_pkg::ST_IDLE;
                end
              end else begin
                st_q      <= tscl_pkg::ST_WACK;
                SDA_OE_N  <= 1'b0;
                wr_q.data <= sh_q;
                wr_q.hi   <= bidx_q == 2'h1;
                wr_q.lo   <= bidx_q == 2'h2;
                if (bidx_q == 2'h0) begin
                  wr_q.ptr <= sh_q[3:0];                      // [RULE_17]
                end
                if (bidx_q != 2'h3) begin
                  bidx_q <= bidx_q + 2'h1;
                end
              end
            end
          end
          tscl_pkg::ST_AACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                st_q     <= tscl_pkg::ST_RBYTE;
                tx_q     <= {rd_word[14:8], 1'b0};
                SDA_OE_N <= rd_word[15];                      // [RULE_09]
                lo_sel_q <= 1'b1;
                rd_evt_q <= 1'b1;                             // [RULE_15]
              end else begin
                st_q     <= tscl_pkg::ST_WBYTE;
                SDA_OE_N <= 1'b1;
              end
            end
          end
          tscl_pkg::ST_WACK: begin
            if (scl_fall) begin
              st_q     <= tscl_pkg::ST_WBYTE;
              SDA_OE_N <= 1'b1;
            end
          end
          tscl_pkg::ST_RBYTE: begin
            if (scl_rise) begin
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (scl_fall) begin
              if (bitcnt_q == 4'h8) begin
                st_q     <= tscl_pkg::ST_RACK;
                bitcnt_q <= 4'h0;
                SDA_OE_N <= 1'b1;
              end else begin
                SDA_OE_N <= tx_q[7];
                tx_q     <= {tx_q[6:0], 1'b0};
              end
            end
          end
          tscl_pkg::ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_s;
            end else if (scl_fall) begin
              if (nack_q) begin
                st_q <= tscl_pkg::ST_IDLE;
              end else begin
                st_q     <= tscl_pkg::ST_RBYTE;
                tx_q     <= lo_sel_q ? {rd_word[6:0], 1'b0}
                                     : {rd_word[14:8], 1'b0};
                SDA_OE_N <= lo_sel_q ? rd_word[7] : rd_word[15];
                lo_sel_q <= ~lo_sel_q;
              end
            end
          end
        endcase
      end
    end
  end

  // Register file
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_q  <= REDUCED ? tscl_pkg::CFG_RST_RED[14:0]
                        : tscl_pkg::CFG_RST_FULL[14:0];       // [RULE_07]
      low_q  <= tscl_pkg::LOW_RST;                            // [RULE_10]
      high_q <= tscl_pkg::HIGH_RST;                           // [RULE_11]
      os_q   <= 1'b0;
    end else begin
      os_q <= wr_q.hi && wr_q.ptr == tscl_pkg::PTR_CFG
              && wr_q.data[tscl_pkg::OS_BIT - 8];             // [RULE_01]
      if (wr_q.hi) begin
        unique case (wr_q.ptr)
          tscl_pkg::PTR_CFG: begin
            // Only the upper byte moves on a single-byte write
            cfg_q[14:8] <= wr_q.data[6:0];                    // [RULE_08]
            if (REDUCED) begin
              cfg_q.rate <= tscl_pkg::RATE_RED;               // [RULE_02]
            end
          end
          tscl_pkg::PTR_LOW:  low_q[15:8]  <= wr_q.data;
          tscl_pkg::PTR_HIGH: high_q[15:8] <= wr_q.data;
          default: ;                                          // [RULE_12]
        endcase
      end
      if (wr_q.lo) begin
        unique case (wr_q.ptr)
          tscl_pkg::PTR_CFG: begin
            if (!REDUCED) begin
              cfg_q.spare <= wr_q.data;                       // [RULE_07]
            end
          end
          tscl_pkg::PTR_LOW:  low_q[7:4]  <= wr_q.data[7:4];  // [RULE_10]
          tscl_pkg::PTR_HIGH: high_q[7:4] <= wr_q.data[7:4];  // [RULE_11]
          default: ;                                          // [RULE_17]
        endcase
      end
    end
  end

  // Pointer survives transfers; reset points at the temperature word
  always_ff @(posedge CLK) begin
    if (RST) begin
      ptr_q <= 4'h0;
    end else if (st_q == tscl_pkg::ST_WBYTE && scl_fall
                 && bitcnt_q == 4'h8 && bidx_q == 2'h0) begin
      ptr_q <= sh_q[3:0];                                     // [RULE_17]
    end
  end

  // Conversion period timer; counts clear to zero in shutdown
  always_comb begin
    unique case (cfg_q.rate)
      2'h0: per_len = tscl_pkg::PER0;
      2'h1: per_len = tscl_pkg::PER1;
      2'h2: per_len = tscl_pkg::PER2;
      2'h3: per_len = REDUCED ? tscl_pkg::PERR : tscl_pkg::PER3;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST || cfg_q.sd) begin                                // [RULE_06]
      tick_q     <= 16'h0000;
      per_q      <= 9'h000;
      per_done_q <= 1'b0;
    end else begin
      per_done_q <= 1'b0;
      if (tick_q == 16'(TICK_CYCLES - 1)) begin
        tick_q <= 16'h0000;
        if (per_q >= per_len - 9'h001) begin                  // [RULE_02]
          per_q      <= 9'h000;
          per_done_q <= 1'b1;
        end else begin
          per_q <= per_q + 9'h001;
        end
      end else begin
        tick_q <= tick_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      CONV_START <= 1'b0;
      SHUTDOWN   <= 1'b0;
      SDA_O      <= 1'b0;
    end else begin
      CONV_START <= os_q | per_done_q;                        // [RULE_01]
      SHUTDOWN   <= cfg_q.sd;                                 // [RULE_06]
    end
  end

  // Threshold flag
  always_comb begin
    unique case (cfg_q.faults)
      2'h0: depth = 3'h1;
      2'h1: depth = 3'h2;
      2'h2: depth = REDUCED ? tscl_pkg::FQ_RED2 : tscl_pkg::FQ_FULL2;
      2'h3: depth = REDUCED ? tscl_pkg::FQ_RED3 : tscl_pkg::FQ_FULL3;
    endcase
    above    = $signed(TEMP_RESULT) >= $signed(high_q[15:4]);
    below    = $signed(TEMP_RESULT) <  $signed(low_q[15:4]);
    tm_chg   = cfg_q.tm != tm_prev_q;
    sd_rise  = cfg_q.sd & ~sd_prev_q;
    hist_clr = tm_chg | (sd_rise & cfg_q.tm);                 // [RULE_16]
    // Comparator looks at the far side of the band; interrupt alternates
    cond     = cfg_q.tm ? (look_low_q ? below : above)
                        : (flag_q ? below : above);           // [RULE_05]
    clr_evt  = cfg_q.tm & flag_q & (rd_evt_q | ALERT_RESP_OK);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fcnt_q     <= 3'h0;
      flag_q     <= 1'b0;
      look_low_q <= 1'b0;
      tm_prev_q  <= 1'b0;
      sd_prev_q  <= 1'b0;
    end else begin
      tm_prev_q <= cfg_q.tm;
      sd_prev_q <= cfg_q.sd;
      if (hist_clr) begin
        fcnt_q     <= 3'h0;                                   // [RULE_16]
        flag_q     <= 1'b0;
        look_low_q <= 1'b0;
      end else if (clr_evt) begin
        flag_q     <= 1'b0;                                   // [RULE_15]
        look_low_q <= ~look_low_q;
        fcnt_q     <= 3'h0;
      end else if (TEMP_VALID && !(cfg_q.tm && flag_q)) begin
        if (!cond) begin
          fcnt_q <= 3'h0;
        end else if (fcnt_q + 3'h1 >= depth) begin            // [RULE_03]
          fcnt_q <= 3'h0;
          flag_q <= cfg_q.tm ? 1'b1 : ~flag_q;                // [RULE_14]
        end else begin
          fcnt_q <= fcnt_q + 3'h1;
        end
      end
    end
  end

  // Open drain: pull low when active xor inverted polarity
  always_ff @(posedge CLK) begin
    if (RST) begin
      ALERT_O    <= 1'b1;
      ALERT_OE_N <= 1'b1;
    end else begin
      ALERT_O    <= ~(flag_q ^ cfg_q.alert_level_invert);                    // [RULE_04]
      ALERT_OE_N <= ~(flag_q ^ cfg_q.alert_level_invert);
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  os_start_a: assert property (os_q |=> CONV_START)           // [RULE_01]
    else $error("one-shot write gave no conversion start");
  rate_fixed_a: assert property (REDUCED |-> cfg_q.rate == 2'h3) // [RULE_02]
    else $error("reduced rate field moved");
  fault_depth_a: assert property (TEMP_VALID && cond && !flag_q // [RULE_03]
      && !hist_clr && !cfg_q.tm && fcnt_q + 3'h1 < depth |=> !flag_q)
    else $error("flag set before fault count reached");
  pin_level_a: assert property (##1 ALERT_OE_N                // [RULE_04]
      == ~($past(flag_q) ^ $past(cfg_q.alert_level_invert)))
    else $error("flag pin level wrong");
  sd_out_a: assert property (##1 SHUTDOWN == $past(cfg_q.sd)) // [RULE_06]
    else $error("shutdown output wrong");
  cfg_low_a: assert property (wr_q.hi && !wr_q.lo             // [RULE_08]
      |=> cfg_q.spare == $past(cfg_q.spare))
    else $error("single-byte write changed low byte");
  lim_nib_a: assert property (low_q[3:0] == 4'h0              // [RULE_10]
      && high_q[3:0] == 4'h0)
    else $error("threshold low nibble not zero");
  int_clear_a: assert property (cfg_q.tm && flag_q && rd_evt_q // [RULE_15]
      && !hist_clr |=> !flag_q ##1 ALERT_OE_N == ~cfg_q.alert_level_invert)
    else $error("register read did not clear flag");
  sd_clear_a: assert property (sd_rise && cfg_q.tm |=> !flag_q) // [RULE_15]
    else $error("shutdown did not clear flag");
  hist_clr_a: assert property (tm_chg                         // [RULE_16]
      |=> !flag_q && fcnt_q == 3'h0)
    else $error("mode change kept history");
  sd_stop_a: assert property (cfg_q.sd |=> !per_done_q)       // [RULE_06]
    else $error("conversion timed during shutdown");

  os_c: cover property (os_q ##1 CONV_START);
  int_c: cover property (cfg_q.tm && $rose(flag_q));
  rd_c: cover property (rd_evt_q);
  wr_c: cover property (wr_q.lo);
endmodule : tscl_regs
`default_nettype wire

// File: bench/tscl_host.sv
`default_nettype none
module tscl_host (
  // Bus pins
  output logic      scl,
  output logic      sda_oe_n,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter of the 125 ns bus clock
  localparam real Q = 31.25;
  logic [6:0] dev = 7'h48;
  int         nacks = 0;

  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  task automatic start_c();
    sda_oe_n = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe_n = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start_c

  task automatic stop_c();
    sda_oe_n = 1'b0;
    #Q scl = 1'b1;
    #Q sda_oe_n = 1'b1;
    #(2 * Q);
  endtask : stop_c

  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_oe_n = b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] o, output logic [7:0] i);
    for (int k = 7; k >= 0; k--) begin
      bit_io(o[k], i[k]);
    end
  endtask : byte_io

  task automatic send(input logic [7:0] b);
    logic [7:0] x;
    logic       a;
    byte_io(b, x);
    bit_io(1'b1, a);
    if (a) begin
      nacks++;
    end
  endtask : send

  task automatic recv(output logic [7:0] b, input logic last);
    logic a;
    byte_io(8'hff, b);
    bit_io(last, a);
  endtask : recv

  // Pointer byte always precedes data
  task automatic wr(input logic [3:0] p, input int n, input logic [15:0] d);
    start_c();
    send({dev, 1'b0});
    send({4'h0, p});
    if (n > 0) begin
      send(d[15:8]);
    end
    if (n > 1) begin
      send(d[7:0]);
    end
    stop_c();
  endtask : wr

  task automatic rd(input int n, output logic [15:0] d);
    d = 16'h0000;
    start_c();
    send({dev, 1'b1});
    recv(d[15:8], n == 1);
    if (n > 1) begin
      recv(d[7:0], 1'b1);
    end
    stop_c();
  endtask : rd
endmodule : tscl_host
`default_nettype wire

// File: bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  // Arbitrary identifier value
  localparam logic [15:0] ID = 16'h5a00;
  typedef struct {
    logic [3:0]  p;
    int          n;
    logic [15:0] d;
    logic [15:0] e;
  } tscl_row_t;
  logic        clk, rst, scl, sda, host_oe_n, sda_oe_n, red_oe_n;
  logic        alert, alert_oe_n, valid, resp_ok, conv, sd;
  logic [11:0] temp;
  logic [15:0] got;
  int          fails = 0;
  int          checks_done = 0;
  int          starts = 0;
  int          c;
  tscl_row_t   rows [10];

  assign sda = host_oe_n & sda_oe_n & red_oe_n;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (conv === 1'b1) begin
      starts <= starts + 1;
    end
  end

  tscl_host host (.scl(scl), .sda_oe_n(host_oe_n), .sda(sda));

  tscl_regs #(.TICK_CYCLES(TICK), .DIE_ID(ID)) dut (
    .CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE_N(sda_oe_n), .ALERT_O(alert), .ALERT_OE_N(alert_oe_n),
    .TEMP_RESULT(temp), .TEMP_VALID(valid), .ALERT_RESP_OK(resp_ok),
    .CONV_START(conv), .SHUTDOWN(sd));

  tscl_regs #(.DEV_ADDR(7'h49), .REDUCED(1'b1), .TICK_CYCLES(TICK)) red (
    .CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE_N(red_oe_n), .ALERT_O(), .ALERT_OE_N(),
    .TEMP_RESULT(temp), .TEMP_VALID(valid), .ALERT_RESP_OK(resp_ok),
    .CONV_START(), .SHUTDOWN());

  task automatic chk(input string what, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic pulse(input logic [11:0] v);
    @(negedge clk);
    temp = v;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse

  // Bounded wait for the next conversion start
  task automatic gap(output int n);
    n = 0;
    while (conv !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
  endtask : gap

  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    $display("BAD watchdog expected done seen hang");
    close_out();
  end

  initial begin
    rst = 1'b1;
    valid = 1'b0;
    resp_ok = 1'b0;
    temp = 12'h123;
    rows = '{
      '{tscl_pkg::PTR_LOW,  0, 16'h0000, 16'h4b00},
      '{tscl_pkg::PTR_HIGH, 0, 16'h0000, 16'h5000},
      '{tscl_pkg::PTR_CFG,  0, 16'h0000, 16'h00ff},
      '{tscl_pkg::PTR_ID,   0, 16'h0000, ID},
      '{tscl_pkg::PTR_LOW,  2, 16'h1230, 16'h1230},
      '{tscl_pkg::PTR_HIGH, 2, 16'h7ff0, 16'h7ff0},
      '{tscl_pkg::PTR_CFG,  2, 16'h1c5a, 16'h1c5a},
      '{tscl_pkg::PTR_CFG,  1, 16'h0600, 16'h065a},
      '{tscl_pkg::PTR_ID,   2, 16'h1111, ID},
      '{tscl_pkg::PTR_TEMP, 2, 16'hffff, 16'h1230}};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      host.wr(rows[i].p, rows[i].n, rows[i].d);
      host.rd(2, got);
      chk($sformatf("row %0d", i), rows[i].e, got);
    end
    $display("test rows done");
    host.wr(tscl_pkg::PTR_CFG, 1, 16'h0100);
    host.rd(1, got);
    chk("single byte read", 16'h0100, got);
    starts = 0;
    host.wr(tscl_pkg::PTR_CFG, 1, 16'h8100);
    repeat (200) @(negedge clk);
    chk("one shot starts", 16'd1, 16'(starts));
    chk("shutdown pin", 16'h0001, {15'h0, sd});
    host.rd(2, got);
    chk("one shot reads 0", 16'h015a, got);
    $display("test one shot done");
    for (int r = 0; r < 4; r++) begin
      host.wr(tscl_pkg::PTR_CFG, 1, 16'(r) << 13);
      repeat (2) begin
        gap(c);
        @(negedge clk);
      end
      gap(c);
      chk("period", 16'((55 << r) * TICK), 16'(c + 1));
    end
    $display("test rates done");
    host.wr(tscl_pkg::PTR_HIGH, 2, 16'h5000);
    host.wr(tscl_pkg::PTR_LOW, 2, 16'h4b00);
    host.wr(tscl_pkg::PTR_CFG, 1, 16'h0800);
    pulse(12'h500);
    chk("one fault", 16'h1, {15'h0, alert_oe_n});
    pulse(12'h500);
    chk("two faults", 16'h0, {15'h0, alert_oe_n});
    chk("flag pin value", 16'h0, {15'h0, alert});
    pulse(12'h4af);
    chk("one below", 16'h0, {15'h0, alert_oe_n});
    pulse(12'h4af);
    chk("two below", 16'h1, {15'h0, alert_oe_n});
    host.wr(tscl_pkg::PTR_CFG, 1, 16'h0c00);
    repeat (3) @(negedge clk);
    chk("inverted idle", 16'h0, {15'h0, alert_oe_n});
    $display("test comparator done");
    host.wr(tscl_pkg::PTR_CFG, 1, 16'h0200);
    pulse(12'h500);
    chk("int set", 16'h0, {15'h0, alert_oe_n});
    pulse(12'h100);
    chk("int held", 16'h0, {15'h0, alert_oe_n});
    host.rd(2, got);
    repeat (3) @(negedge clk);
    chk("read clears", 16'h1, {15'h0, alert_oe_n});
    pulse(12'h4af);
    chk("low side set", 16'h0, {15'h0, alert_oe_n});
    @(negedge clk);
    resp_ok = 1'b1;
    @(negedge clk);
    resp_ok = 1'b0;
    repeat (3) @(negedge clk);
    chk("response clears", 16'h1, {15'h0, alert_oe_n});
    pulse(12'h500);
    chk("int again", 16'h0, {15'h0, alert_oe_n});
    host.wr(tscl_pkg::PTR_CFG, 1, 16'h0300);
    repeat (3) @(negedge clk);
    chk("shutdown clears", 16'h1, {15'h0, alert_oe_n});
    $display("test interrupt done");
    host.dev = 7'h49;
    host.wr(tscl_pkg::PTR_CFG, 1, 16'h0000);
    host.rd(2, got);
    chk("reduced config", 16'h60a0, got);
    host.wr(tscl_pkg::PTR_ID, 0, 16'h0000);
    host.rd(2, got);
    chk("reduced no id", 16'h0000, got);
    chk("bus acks", 16'h0, 16'(host.nacks));
    $display("test reduced done");
    @(negedge clk);
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("reset shutdown", 16'h0, {15'h0, sd});
    host.dev = 7'h48;
    host.wr(tscl_pkg::PTR_CFG, 0, 16'h0000);
    host.rd(2, got);
    chk("reset config", 16'h00ff, got);
    $display("test reset done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
